// *** rtl/capm_timer.sv ***
// Behaviour
// RQ1: After an up-count period match, count down starting at period plus one.
// RQ2: Signal a second period match when passing period at down-count start.
// RQ3: Period-match trigger line pulses at both period matches of a cycle.
// RQ4: Period-match interrupt and shadow transfer fire once, on the up-count match.
// RQ5: Select multi-channel trigger instead of period-match line for one trigger.
// RQ6: Select field 101 requests pattern shadow transfer on period match.
// RQ7: Sync field 00 makes the requested pattern transfer immediate.
// RQ8: Pattern CF enables compare outputs and their complementary outputs; the code enables channels 0 and 1 only, channel 2 stays off.
// RQ9: Down-count reaching zero reverses to counting up, alternating continuously.
`timescale 1ns/1ns
module capm_timer
    import capm_pkg::*;
#(
    parameter int CNT_W = CAPM_CNT_W
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic [CNT_W-1:0] period_i,
    input wire logic [2:0] shadow_request_select_i,
    input wire logic [1:0] shadow_sync_select_i,
    input wire logic [7:0] multichannel_output_shadow_i,
    input wire logic [1:0] trigger_select_i,
    output logic [CNT_W-1:0] main_up_down_counter_o,
    output logic counting_down_o,
    output logic period_match_o,
    output logic period_match_irq_o,
    output logic trigger_line_period_match_o,
    output logic trigger_line_multichannel_o,
    output logic converter_trigger_o,
    output logic [2:0] compare_outputs_o,
    output logic [2:0] complementary_compare_outputs_o
);
    localparam int CH_N = 3;

    // ==========================================
    // Helpers
    // Routes the chosen source to the converter; spare codes stay quiet
    function automatic logic capm_route(
        input logic [1:0] sel,
        input logic pm_pulse,
        input logic mc_pulse
    );
        logic routed;
        routed = 1'b0;
        if (sel == CAPM_TRIG_MC) begin
            routed = mc_pulse; // [RQ5]
        end else if (sel == CAPM_TRIG_PM) begin
            routed = pm_pulse; // [RQ3]
        end
        return routed;
    endfunction : capm_route

    // ==========================================
    // Declarations
    capm_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period_shadow;
    logic pm_hit;
    logic pm_up;
    logic cnt_zero;
    logic mc_request;
    logic mc_direct;
    logic mc_transfer;
    logic [7:0] pattern;
    logic [CH_N-1:0] ch_true;
    logic [CH_N-1:0] ch_comp;

    // ==========================================
    // Counter
    assign pm_hit = (state != CAPM_IDLE) && (cnt == period_shadow);
    assign pm_up = pm_hit && (state == CAPM_UP); // [RQ4]
    assign cnt_zero = (cnt == '0);

    // Leaving run parks the count where it stands
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state <= CAPM_IDLE;
        end else if (ce_i) begin
            case (state)
                CAPM_IDLE: begin
                    if (run_i) begin
                        state <= CAPM_UP;
                    end
                end
                CAPM_UP: begin
                    if (!run_i) begin
                        state <= CAPM_IDLE;
                    end else if (pm_hit) begin
                        state <= CAPM_DOWN; // [RQ1]
                    end
                end
                CAPM_DOWN: begin
                    if (!run_i) begin
                        state <= CAPM_IDLE;
                    end else if (cnt_zero) begin
                        state <= CAPM_UP; // [RQ9]
                    end
                end
                default: begin
                    state <= CAPM_IDLE;
                end
            endcase
        end
    end

    // Overshoot to period plus one, so the down phase meets the period again
    // A restart resumes from the held count
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt <= '0;
        end else if (ce_i && run_i) begin
            if (state == CAPM_UP) begin
                cnt <= cnt + 1'b1; // [RQ1]
            end else if (state == CAPM_DOWN && cnt_zero) begin
                cnt <= cnt + 1'b1; // [RQ9]
            end else if (state == CAPM_DOWN) begin
                cnt <= cnt - 1'b1; // [RQ2]
            end
        end
    end

    // Period shadow loads while idle and on the up-count match, not on the second one
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            period_shadow <= CNT_W'(CAPM_PERIOD_RST);
        end else if (ce_i && (state == CAPM_IDLE || pm_up)) begin
            period_shadow <= period_i; // [RQ4]
        end
    end

    // ==========================================
    // Events and triggers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            period_match_o <= 1'b0;
        end else if (ce_i) begin
            period_match_o <= pm_hit; // [RQ2]
        end
    end

    // Internal period-match actions only see the up-count match
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            period_match_irq_o <= 1'b0;
        end else if (ce_i) begin
            period_match_irq_o <= pm_up; // [RQ4]
        end
    end

    // Both matches reach this line; a converter on it starts twice
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            trigger_line_period_match_o <= 1'b0;
        end else if (ce_i) begin
            trigger_line_period_match_o <= pm_hit; // [RQ3]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            trigger_line_multichannel_o <= 1'b0;
        end else if (ce_i) begin
            trigger_line_multichannel_o <= mc_transfer; // [RQ5]
        end
    end

    // Multi-channel source gives one trigger per cycle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            converter_trigger_o <= 1'b0;
        end else if (ce_i) begin
            converter_trigger_o <= capm_route(trigger_select_i, pm_hit, mc_transfer); // [RQ3][RQ5]
        end
    end

    // ==========================================
    // Multi-channel pattern shadow transfer
    // Only direct sync is modelled; other sync settings never transfer
    assign mc_request = (shadow_request_select_i == CAPM_SEL_PERIOD) && pm_up; // [RQ6]
    assign mc_direct = (shadow_sync_select_i == CAPM_SYNC_DIRECT); // [RQ7]
    assign mc_transfer = mc_request && mc_direct; // [RQ7]

    // Pattern stands until the next accepted transfer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pattern <= CAPM_PATTERN_RST;
        end else if (ce_i && mc_transfer) begin
            pattern <= multichannel_output_shadow_i;
        end
    end

    // ==========================================
    // Compare outputs
    // Pattern bits 0, 2 and 4 feed true outputs, bits 1, 3 and 5 their complements; bits 6 and 7 feed nothing
    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : gen_ch
            assign ch_true[g] = pattern[2*g]; // [RQ8]
            assign ch_comp[g] = pattern[2*g+1]; // [RQ8]
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            compare_outputs_o <= '0;
            complementary_compare_outputs_o <= '0;
        end else if (ce_i) begin
            compare_outputs_o <= ch_true; // [RQ8]
            complementary_compare_outputs_o <= ch_comp; // [RQ8]
        end
    end

    // ==========================================
    // Status
    assign main_up_down_counter_o = cnt;
    assign counting_down_o = (state == CAPM_DOWN);
endmodule : capm_timer

// *** inc/capm_pkg.sv ***
package capm_pkg;
    localparam int CAPM_CNT_W = 16;
    localparam logic [15:0] CAPM_PERIOD_RST = 16'h00ff;
    localparam logic [2:0] CAPM_SEL_PERIOD = 3'h5;
    localparam logic [1:0] CAPM_SYNC_DIRECT = 2'h0;
    localparam logic [7:0] CAPM_PATTERN_ALL = 8'hcf;
    localparam logic [7:0] CAPM_PATTERN_RST = 8'h00;
    localparam logic [1:0] CAPM_TRIG_PM = 2'h0;
    localparam logic [1:0] CAPM_TRIG_MC = 2'h1;

    typedef enum logic [1:0] {
        CAPM_IDLE = 2'b00,
        CAPM_UP = 2'b01,
        CAPM_DOWN = 2'b11
    } capm_state_type;
endpackage : capm_pkg

// *** test/capm_adc_model.sv ***
`timescale 1ns/1ns
// ====
// Converter model
module capm_adc_model (
    input wire logic clk_i,
    input wire logic start_i,
    output int conversions_o = 0
);
    // A doubled pulse starts a second conversion, as a real converter would
    always @(posedge clk_i) if (start_i) conversions_o <= conversions_o + 1;
endmodule : capm_adc_model

// *** test/capm_properties.sv ***
`timescale 1ns/1ns
// ====
// Timer checks
module capm_properties #(parameter int CNT_W = 16) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic run_i,
    input wire logic trigger_line_period_match_o,
    input wire logic trigger_line_multichannel_o,
    input wire logic [CNT_W-1:0] main_up_down_counter_o,
    input wire logic counting_down_o,
    input wire logic period_match_o,
    input wire logic period_match_irq_o
);
    wire logic [CNT_W-1:0] c = main_up_down_counter_o;
    wire logic dn = counting_down_o;
    wire logic irq = period_match_irq_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    AST_DOWN: assert property (irq |-> dn && c == $past(c) + 1) else $error("down");
    AST_ENTER: assert property ($rose(dn) |-> irq) else $error("enter");
    AST_AGAIN: assert property (irq |-> ##2 period_match_o && dn) else $error("again");
    AST_STEP: assert property (dn && c != 0 && run_i |=> dn && c == $past(c) - 1) else $error("step");
    AST_TRIG_TWICE: assert property (irq |-> trigger_line_period_match_o ##2 trigger_line_period_match_o) else $error("trig twice");
    AST_MC_ONCE: assert property (trigger_line_multichannel_o |-> irq ##1 !trigger_line_multichannel_o) else $error("mc once");
    // Second match falls in the down phase, so it must stay silent
    AST_ONCE: assert property (period_match_o && $past(dn) |-> !irq) else $error("once");
    AST_PAIR: assert property (irq |-> period_match_o ##1 !irq) else $error("pair");
    AST_TURN: assert property (dn && c == 0 && run_i |=> !dn && c == 1) else $error("turn");
    AST_FALL: assert property ($fell(dn) && $past(run_i) |-> $past(c) == 0) else $error("fall");
endmodule : capm_properties

// *** test/center_aligned_period_match_trigger_bench.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH %0t value", $time); end end
// ====
// Bench
module center_aligned_period_match_trigger_bench;
    logic clk_i = 0, resetn_i = 0, run_i = 0, dn, irq, tr;
    logic [2:0] cmp, cmq;
    logic [15:0] cnt;
    logic [24:0] row = 25'h0;
    int bad_count = 0, num_checks = 0, conv, c0, k;
    // Trigger, request, sync, pattern, conversions in 4 rounds, outputs
    logic [24:0] rows [4] = '{{2'h0, 3'h5, 2'h0, 8'hcf, 4'h8, 3'h3, 3'h3},
        {2'h1, 3'h5, 2'h0, 8'h30, 4'h4, 3'h4, 3'h4},
        {2'h2, 3'h4, 2'h0, 8'hcf, 4'h0, 3'h4, 3'h4},
        {2'h1, 3'h5, 2'h1, 8'hcf, 4'h0, 3'h4, 3'h4}};
    always #2 clk_i = ~clk_i;
    capm_timer i_capm_timer (.clk_i, .resetn_i, .ce_i(1'b1), .run_i, .period_i(16'h0003),
        .trigger_select_i(row[24:23]), .shadow_request_select_i(row[22:20]),
        .shadow_sync_select_i(row[19:18]), .multichannel_output_shadow_i(row[17:10]),
        .main_up_down_counter_o(cnt), .counting_down_o(dn), .period_match_o(),
        .period_match_irq_o(irq), .trigger_line_period_match_o(),
        .trigger_line_multichannel_o(), .converter_trigger_o(tr), .compare_outputs_o(cmp),
        .complementary_compare_outputs_o(cmq));
    capm_adc_model i_capm_adc_model (.clk_i, .start_i(tr), .conversions_o(conv));
    task automatic test_done;
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (3) @(negedge clk_i);
        resetn_i = 1;
        @(negedge clk_i);
        foreach (rows[i]) begin
            row = rows[i];
            run_i = 1;
            for (k = 0; k < 99 && irq !== 1'b1; k++) @(negedge clk_i);
            if (k == 99) begin
                bad_count++;
                test_done();
            end
            c0 = conv;
            repeat (32) @(negedge clk_i);
            `CHK(conv - c0, int'(row[9:6]))
            `CHK({cmp, cmq}, row[5:0])
            // Park in the up phase, so a restart meets a match soon
            repeat (6) @(negedge clk_i);
            run_i = 0;
            @(negedge clk_i);
            $display("row %0d", i);
        end
        resetn_i = 0;
        @(negedge clk_i);
        `CHK({cnt, dn, cmp, cmq}, 23'h0)
        $display("reset");
        test_done();
    end
endmodule : center_aligned_period_match_trigger_bench
bind capm_timer capm_properties #(.CNT_W(CNT_W)) i_capm_properties (.*);
